// >>> src/sgt_pkg.sv
// Purpose: Shared constants and carriers for the sector guard, training
//          pattern and secure region logic.
// Assumes: Single-bit SPI framing, mode 0, opcodes sent MSB first.
// Notes:   Nonvolatile state is modelled in flops that only the ship
//          initialisation input restores.
package sgt_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int SGT_SECTORS = 256;
  localparam int SGT_SECT_W = 8;
  localparam int SGT_SECT_LSB = 18;
  localparam int SGT_SEC_BYTES = 1024;
  localparam int SGT_SEC_AW = 10;
  localparam int SGT_REGIONS = 32;
  localparam int SGT_REGION_LSB = 5;
  localparam int SGT_CHUNKS = 64;
  localparam int SGT_CHUNK_LSB = 4;
  localparam int SGT_FIFO_WIDTH = 8;
  localparam int SGT_FIFO_DEPTH = 16;
  localparam int SGT_TRAIN_EDGES = 8;
  localparam logic [9:0] SGT_LOCK_BYTE_BASE = 10'h010;
  localparam logic [9:0] SGT_LOCK_BYTE_LAST = 10'h013;

  // ----------------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------------
  localparam logic [7:0] SGT_CMD_LOCK_RD = 8'hA7;
  localparam logic [7:0] SGT_CMD_LOCK_WR = 8'hA6;
  localparam logic [7:0] SGT_CMD_NVG_RD = 8'hFC;
  localparam logic [7:0] SGT_CMD_NVG_RD4 = 8'hE2;
  localparam logic [7:0] SGT_CMD_NVG_PG = 8'hFD;
  localparam logic [7:0] SGT_CMD_NVG_PG4 = 8'hE3;
  localparam logic [7:0] SGT_CMD_NVG_ER = 8'hE4;
  localparam logic [7:0] SGT_CMD_VG_RD = 8'hFA;
  localparam logic [7:0] SGT_CMD_VG_RD4 = 8'hE0;
  localparam logic [7:0] SGT_CMD_VG_WR = 8'hFB;
  localparam logic [7:0] SGT_CMD_VG_WR4 = 8'hE1;
  localparam logic [7:0] SGT_CMD_NVP_PG = 8'h43;
  localparam logic [7:0] SGT_CMD_VP_WR = 8'h4A;
  localparam logic [7:0] SGT_CMD_PAT_RD = 8'h41;
  localparam logic [7:0] SGT_CMD_SEC_PG = 8'h42;
  localparam logic [7:0] SGT_CMD_SEC_RD = 8'h4B;
  localparam logic [7:0] SGT_CMD_DDR_TRAIN = 8'hEE;

  // ----------------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------------
  localparam logic [7:0] SGT_GUARD_ON = 8'h00;
  localparam logic [7:0] SGT_GUARD_OFF = 8'hFF;
  localparam logic [7:0] SGT_NV_PAT_RESET = 8'h00;
  localparam logic [6:0] SGT_LOCK_RSVD = 7'h00;
  localparam logic [7:0] SGT_ERASED = 8'hFF;
  localparam logic [2:0] SGT_PINS_IDLE = 3'h2;

  typedef enum logic [1:0] {SGT_A3, SGT_A4, SGT_A0} sgt_alen_e;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } sgt_spi_in_s;

  typedef struct packed {
    logic [3:0] io;
    logic [3:0] oe;
  } sgt_io_out_s;

endpackage

// >>> src/sgt_guard.sv
// Purpose: Sector guard, lock, training pattern and secure region logic
//          behind a sampled SPI slave port.
// Assumes: SPI mode 0 on io0/io1, sck well below a quarter of i_clock.
// Notes:   Secure region program data waits in a page FIFO and is
//          committed when chip select rises.
//
// Summary of operation
// - Lock bit 0 refuses nonvolatile guard programming
// - Lock resets to 1 persistent, 0 password
// - Lock register volatile, cleared by write command, upper bits zero
// - Nonvolatile guard reads 00h protected, FFh not
// - Nonvolatile guards ship erased, no volatile shadow
// - Volatile guard write 00h protects, FFh frees
// - Volatile guards reset to protected
// - One-time pattern ships 00h, programs once only
// - One-time pattern program also loads volatile copy
// - Volatile pattern writable, reloads at power cycle
// - Training pattern MSB first, all lines equal
// - Pattern 00h drives no preamble
// - Secure region 1024 bytes, 32 lockable regions
// - Secure read uses fast-read framing, host stays inside
// - Secure program repeatable, never erasable
// - ECC disabled on second program of chunk
// - Out-of-range secure program silently ignored
// - Frozen in-range secure program fails, sets error flag
// - Protection mode never guards secure region
// - Decode nonvolatile guard read, program, erase
// - Decode volatile guard read and write
// - Sector protected when either guard is 0
// - Persistent lock cleared by command, never set
// - Freeze input high when chip select rises blocks that secure program, latched for the drain
`timescale 1ns/1ps

// --------------------------------------------------------------------------
// Page buffer FIFO
// --------------------------------------------------------------------------
module sgt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// --------------------------------------------------------------------------
// Top
// --------------------------------------------------------------------------
module sgt_guard (
  // Clock and resets
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_ship_init,
  // SPI pins
  input wire sgt_pkg::sgt_spi_in_s i_spi,
  output sgt_pkg::sgt_io_out_s o_io,
  // Configuration and status
  input wire logic [1:0] i_protection_mode,
  input wire logic i_freeze,
  input wire logic i_clear_program_error,
  output logic o_program_error,
  output logic o_guard_lock,
  output logic o_busy,
  // Queries
  input wire logic [7:0] i_query_sector,
  output logic o_sector_protected,
  input wire logic [5:0] i_query_chunk,
  output logic o_chunk_ecc_off
);
  import sgt_pkg::*;

  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_TRAIN, ST_SKIP
  } sgt_state_e;

  // ------------------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------------------
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pins;
  logic [2:0] pins_prev;
  logic sck_rise;
  logic sck_fall;
  logic cs_start;
  logic cs_end;
  logic selected;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sync1 <= SGT_PINS_IDLE;
      sync2 <= SGT_PINS_IDLE;
      sync3 <= SGT_PINS_IDLE;
      pins <= SGT_PINS_IDLE;
      pins_prev <= SGT_PINS_IDLE;
    end else begin
      sync1 <= i_spi;
      sync2 <= sync1;
      sync3 <= sync2;
      // A bit moves only once two stages agree, which also filters glitches
      for (int i = 0; i < 3; i++) begin
        if (sync2[i] == sync3[i]) begin
          pins[i] <= sync3[i];
        end
      end
      pins_prev <= pins;
    end
  end

  assign selected = !pins[1];
  assign sck_rise = selected && pins[2] && !pins_prev[2];
  assign sck_fall = selected && !pins[2] && pins_prev[2];
  assign cs_start = pins_prev[1] && !pins[1];
  assign cs_end = !pins_prev[1] && pins[1];

  // ------------------------------------------------------------------------
  // Byte receiver
  // ------------------------------------------------------------------------
  logic [2:0] bit_cnt;
  logic [6:0] rx_shift;
  logic byte_done;
  logic [7:0] rx_byte;

  always_ff @(posedge i_clock) begin
    if (i_reset || cs_start) begin
      bit_cnt <= '0;
      rx_shift <= '0;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 1'b1;
      rx_shift <= {rx_shift[5:0], pins[0]};
    end
  end

  assign byte_done = sck_rise && (bit_cnt == 3'h7);
  assign rx_byte = {rx_shift, pins[0]};

  // ------------------------------------------------------------------------
  // Nonvolatile and volatile state
  // ------------------------------------------------------------------------
  logic [SGT_SECTORS-1:0] nv_sector_guard;
  logic [SGT_SECTORS-1:0] volatile_sector_guard;
  logic guard_lock_bit;
  logic [7:0] nv_pattern_field;
  logic nv_pattern_done;
  logic [7:0] volatile_pattern_field;
  logic [7:0] sec_mem [SGT_SEC_BYTES];
  logic [SGT_SEC_BYTES-1:0] sec_written;
  logic [SGT_REGIONS-1:0] region_open;
  logic [SGT_CHUNKS-1:0] chunk_prog;
  logic [SGT_CHUNKS-1:0] chunk_before;
  logic [SGT_CHUNKS-1:0] chunk_ecc_off;

  // ------------------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------------------
  sgt_state_e state;
  sgt_state_e next_state;
  logic [7:0] opcode;
  logic [31:0] addr;
  logic [31:0] next_addr;
  logic [2:0] addr_left;
  logic [2:0] next_addr_left;
  logic addr_done;
  logic op_valid;
  logic load_tx;
  logic start_train;
  logic [7:0] tx_value;
  logic [7:0] tx_op;
  logic [SGT_SECT_W-1:0] sector;
  logic [SGT_SEC_AW-1:0] rd_index;
  logic draining;

  assign sector = next_addr[SGT_SECT_LSB +: SGT_SECT_W];
  assign rd_index = next_addr[SGT_SEC_AW-1:0];

  always_comb begin
    next_state = state;
    next_addr = addr;
    next_addr_left = addr_left;
    load_tx = 1'b0;
    start_train = 1'b0;
    if (cs_start) begin
      next_state = ST_OPCODE;
      next_addr = '0;
    end else if (byte_done) begin
      case (state)
        ST_OPCODE: begin
          next_state = ST_SKIP;
          if (!draining) begin
            case (rx_byte)
              SGT_CMD_NVG_RD, SGT_CMD_NVG_PG, SGT_CMD_VG_RD, SGT_CMD_VG_WR,
              SGT_CMD_SEC_PG, SGT_CMD_SEC_RD, SGT_CMD_DDR_TRAIN: begin
                next_state = ST_ADDR;
                next_addr_left = 3'h3;
              end
              SGT_CMD_NVG_RD4, SGT_CMD_NVG_PG4, SGT_CMD_VG_RD4,
              SGT_CMD_VG_WR4: begin
                next_state = ST_ADDR;
                next_addr_left = 3'h4;
              end
              SGT_CMD_LOCK_RD, SGT_CMD_PAT_RD: begin
                next_state = ST_RDATA;
                load_tx = 1'b1;
              end
              SGT_CMD_NVP_PG, SGT_CMD_VP_WR: begin
                next_state = ST_WDATA;
              end
              default: begin
                next_state = ST_SKIP;
              end
            endcase
          end
        end
        ST_ADDR: begin
          next_addr = {addr[23:0], rx_byte};
          next_addr_left = addr_left - 1'b1;
          if (addr_left == 3'h1) begin
            case (opcode)
              SGT_CMD_SEC_RD: next_state = ST_DUMMY;
              SGT_CMD_SEC_PG, SGT_CMD_VG_WR, SGT_CMD_VG_WR4: next_state = ST_WDATA;
              SGT_CMD_DDR_TRAIN: begin
                next_state = ST_TRAIN;
                start_train = 1'b1;
              end
              SGT_CMD_NVG_PG, SGT_CMD_NVG_PG4: next_state = ST_SKIP;
              default: begin
                next_state = ST_RDATA;
                load_tx = 1'b1;
              end
            endcase
          end
        end
        ST_DUMMY: begin
          next_state = ST_RDATA;
          load_tx = 1'b1;
        end
        ST_RDATA: begin
          load_tx = 1'b1;
          if (opcode == SGT_CMD_SEC_RD) begin
            next_addr = addr + 32'h1;
          end
        end
        ST_WDATA: begin
          if (opcode == SGT_CMD_NVP_PG) begin
            next_state = ST_SKIP;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state <= ST_SKIP;
      opcode <= '0;
      addr <= '0;
      addr_left <= '0;
      addr_done <= 1'b0;
      op_valid <= 1'b0;
    end else begin
      state <= next_state;
      addr <= next_addr;
      addr_left <= next_addr_left;
      if (cs_start) begin
        addr_done <= 1'b0;
        op_valid <= 1'b0;
      end else if (byte_done && state == ST_OPCODE) begin
        opcode <= rx_byte;
        op_valid <= !draining;
      end else if (byte_done && state == ST_ADDR && addr_left == 3'h1) begin
        addr_done <= 1'b1;
      end
    end
  end

  // The opcode flop is still stale on the edge that completes the opcode byte
  assign tx_op = (state == ST_OPCODE) ? rx_byte : opcode;

  // Value for the next byte to shift out
  always_comb begin
    case (tx_op)
      SGT_CMD_LOCK_RD: tx_value = {SGT_LOCK_RSVD, guard_lock_bit};
      SGT_CMD_NVG_RD, SGT_CMD_NVG_RD4: begin
        tx_value = nv_sector_guard[sector] ? SGT_GUARD_OFF : SGT_GUARD_ON;
      end
      SGT_CMD_VG_RD, SGT_CMD_VG_RD4: begin
        tx_value = volatile_sector_guard[sector] ? SGT_GUARD_OFF : SGT_GUARD_ON;
      end
      SGT_CMD_PAT_RD: tx_value = volatile_pattern_field;
      // Beyond 1 kB the index wraps; that data is undefined to the host
      SGT_CMD_SEC_RD: tx_value = sec_written[rd_index] ? sec_mem[rd_index] : SGT_ERASED;
      default: tx_value = '0;
    endcase
  end

  // ------------------------------------------------------------------------
  // Output drivers
  // ------------------------------------------------------------------------
  logic [7:0] tx_shift;
  logic [7:0] pat_shift;
  logic [3:0] pat_edges;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      tx_shift <= '0;
      pat_shift <= '0;
      pat_edges <= '0;
      o_io <= '0;
    end else begin
      if (load_tx) begin
        tx_shift <= tx_value;
      end else if (sck_fall && state == ST_RDATA) begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
      if (start_train) begin
        pat_shift <= volatile_pattern_field;
        pat_edges <= '0;
      end else if ((sck_rise || sck_fall) && state == ST_TRAIN) begin
        pat_shift <= {pat_shift[6:0], 1'b0};
        pat_edges <= pat_edges + 1'b1;
      end
      if (state == ST_TRAIN && selected && pat_edges < 4'(SGT_TRAIN_EDGES)) begin
        o_io.io <= {4{pat_shift[7]}};
        o_io.oe <= (volatile_pattern_field != 8'h00) ? 4'hF : 4'h0;
      end else begin
        o_io.io <= {2'b00, tx_shift[7], 1'b0};
        o_io.oe <= {2'b00, (state == ST_RDATA) && selected, 1'b0};
      end
    end
  end

  // ------------------------------------------------------------------------
  // Guards and lock
  // ------------------------------------------------------------------------
  logic commit_nvg_pg;
  logic commit_nvg_er;
  logic guard_refused;
  logic [SGT_SECT_W-1:0] cur_sector;

  assign cur_sector = addr[SGT_SECT_LSB +: SGT_SECT_W];
  assign commit_nvg_pg = cs_end && addr_done &&
                         (opcode == SGT_CMD_NVG_PG || opcode == SGT_CMD_NVG_PG4);
  assign commit_nvg_er = cs_end && op_valid && opcode == SGT_CMD_NVG_ER;
  assign guard_refused = (commit_nvg_pg || commit_nvg_er) && !guard_lock_bit;

  always_ff @(posedge i_clock) begin
    if (i_ship_init) begin
      nv_sector_guard <= '1;
    end else if (guard_lock_bit) begin
      if (commit_nvg_pg) begin
        nv_sector_guard[cur_sector] <= 1'b0;
      end else if (commit_nvg_er) begin
        nv_sector_guard <= '1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      volatile_sector_guard <= '0;
    end else if (byte_done && state == ST_WDATA &&
                 (opcode == SGT_CMD_VG_WR || opcode == SGT_CMD_VG_WR4)) begin
      // Other data values leave the guard as it is
      if (rx_byte == SGT_GUARD_ON) begin
        volatile_sector_guard[cur_sector] <= 1'b0;
      end else if (rx_byte == SGT_GUARD_OFF) begin
        volatile_sector_guard[cur_sector] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      guard_lock_bit <= i_protection_mode[1];
    end else if (cs_end && op_valid && opcode == SGT_CMD_LOCK_WR) begin
      guard_lock_bit <= 1'b0;
    end
  end

  assign o_guard_lock = guard_lock_bit;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_sector_protected <= 1'b1;
    end else begin
      o_sector_protected <= !nv_sector_guard[i_query_sector] ||
                            !volatile_sector_guard[i_query_sector];
    end
  end

  // ------------------------------------------------------------------------
  // Training pattern
  // ------------------------------------------------------------------------
  logic pat_byte;

  assign pat_byte = byte_done && state == ST_WDATA;

  always_ff @(posedge i_clock) begin
    if (i_ship_init) begin
      nv_pattern_field <= SGT_NV_PAT_RESET;
      nv_pattern_done <= 1'b0;
    end else if (pat_byte && opcode == SGT_CMD_NVP_PG && !nv_pattern_done) begin
      nv_pattern_field <= rx_byte;
      nv_pattern_done <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_ship_init) begin
      volatile_pattern_field <= SGT_NV_PAT_RESET;
    end else if (i_reset) begin
      volatile_pattern_field <= nv_pattern_field;
    end else if (pat_byte && opcode == SGT_CMD_NVP_PG && !nv_pattern_done) begin
      volatile_pattern_field <= rx_byte;
    end else if (pat_byte && opcode == SGT_CMD_VP_WR) begin
      volatile_pattern_field <= rx_byte;
    end
  end

  // ------------------------------------------------------------------------
  // Secure region program path
  // ------------------------------------------------------------------------
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic discard;
  logic [10:0] wr_addr;
  logic wr_fire;
  logic wr_ok;
  logic sec_commit;
  logic sec_in_range;
  logic [SGT_SEC_AW-1:0] wr_index;

  assign sec_commit = cs_end && addr_done && opcode == SGT_CMD_SEC_PG;
  assign sec_in_range = (addr[23:SGT_SEC_AW] == '0);
  assign wr_index = wr_addr[SGT_SEC_AW-1:0];
  assign wr_fire = draining && fifo_out_valid && !discard;
  // Bytes past the top of the region drop off rather than wrap
  assign wr_ok = wr_fire && !wr_addr[SGT_SEC_AW] &&
                 region_open[wr_index[SGT_SEC_AW-1:SGT_REGION_LSB]];

  sgt_fifo #(
    .WIDTH(SGT_FIFO_WIDTH),
    .DEPTH(SGT_FIFO_DEPTH)
  ) u_page_fifo (
    .i_clock(i_clock),
    .i_reset(i_reset),
    // A full buffer drops further bytes of the same page
    .i_in_valid(byte_done && state == ST_WDATA && opcode == SGT_CMD_SEC_PG),
    .i_in_data(rx_byte),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(draining)
  );

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      draining <= 1'b0;
      discard <= 1'b0;
      wr_addr <= '0;
    end else if (sec_commit && !draining) begin
      // Ignoring the protection mode here is deliberate
      draining <= 1'b1;
      discard <= !sec_in_range || i_freeze;
      wr_addr <= {1'b0, addr[SGT_SEC_AW-1:0]};
    end else if (draining) begin
      if (!fifo_out_valid) begin
        draining <= 1'b0;
      end else begin
        wr_addr <= wr_addr + 11'h1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (wr_ok) begin
      sec_mem[wr_index] <= fifo_out_data &
                           (sec_written[wr_index] ? sec_mem[wr_index] : SGT_ERASED);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_ship_init) begin
      sec_written <= '0;
      region_open <= '1;
      chunk_prog <= '0;
      chunk_before <= '0;
      chunk_ecc_off <= '0;
    end else begin
      if (sec_commit && !draining) begin
        chunk_before <= chunk_prog;
      end
      // There is no erase path for any of this state
      if (wr_ok) begin
        sec_written[wr_index] <= 1'b1;
        chunk_prog[wr_index[SGT_SEC_AW-1:SGT_CHUNK_LSB]] <= 1'b1;
        if (chunk_before[wr_index[SGT_SEC_AW-1:SGT_CHUNK_LSB]]) begin
          chunk_ecc_off[wr_index[SGT_SEC_AW-1:SGT_CHUNK_LSB]] <= 1'b1;
        end
        if (wr_index >= SGT_LOCK_BYTE_BASE && wr_index <= SGT_LOCK_BYTE_LAST) begin
          region_open[8*(wr_index[1:0]) +: 8] <=
            region_open[8*(wr_index[1:0]) +: 8] & fifo_out_data;
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_chunk_ecc_off <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_chunk_ecc_off <= chunk_ecc_off[i_query_chunk];
      o_busy <= draining;
    end
  end

  // ------------------------------------------------------------------------
  // Program error flag
  // ------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_program_error <= 1'b0;
    end else if ((sec_commit && !draining && sec_in_range && i_freeze) ||
                 guard_refused) begin
      o_program_error <= 1'b1;
    end else if (i_clear_program_error) begin
      o_program_error <= 1'b0;
    end
  end

endmodule

// >>> test/sgt_guard_chk.sv
// Purpose: Port checks bound to sgt_guard.
// Assumes: One clock domain, sync reset.
// Notes:   Pin sampling lags sck by up to four clocks.
`timescale 1ns/1ps
module sgt_guard_chk (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Watched ports
  input wire sgt_pkg::sgt_spi_in_s i_spi,
  input wire sgt_pkg::sgt_io_out_s o_io,
  input wire logic [1:0] i_protection_mode,
  input wire logic i_clear_program_error,
  input wire logic [5:0] i_query_chunk,
  input wire logic o_program_error,
  input wire logic o_guard_lock,
  input wire logic o_busy,
  input wire logic o_sector_protected,
  input wire logic o_chunk_ecc_off
);
  import sgt_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  a_lock_reset:
    assert property ($fell(i_reset) |-> o_guard_lock == $past(i_protection_mode[1]))
      else $error("lock reset value");
  a_lock_no_set: assert property (!o_guard_lock |=> !o_guard_lock) else $error("lock set");
  a_guard_reset:
    assert property ($fell(i_reset) |-> o_sector_protected) else $error("guard reset");
  a_err_sticky:
    assert property (o_program_error && !i_clear_program_error |=> o_program_error)
      else $error("error lost");
  a_err_at_end:
    assert property ($rose(o_program_error) |-> i_spi.cs_n) else $error("error mid frame");
  a_lines_equal:
    assert property (o_io.oe == 4'hF |-> o_io.io == 4'h0 || o_io.io == 4'hF)
      else $error("lines differ");
  a_busy_bound: assert property ($rose(o_busy) |-> ##[1:24] !o_busy) else $error("busy");
  a_ecc_sticky:
    assert property (o_chunk_ecc_off && $stable(i_query_chunk) |=> o_chunk_ecc_off)
      else $error("ecc back on");
  c_error: cover property ($rose(o_program_error));
  c_train: cover property (o_io.oe == 4'hF);
  c_busy: cover property ($rose(o_busy));
endmodule

bind sgt_guard sgt_guard_chk chk (.i_clock(i_clock), .i_reset(i_reset), .i_spi(i_spi),
  .o_io(o_io), .i_protection_mode(i_protection_mode), .i_query_chunk(i_query_chunk),
  .i_clear_program_error(i_clear_program_error), .o_program_error(o_program_error),
  .o_guard_lock(o_guard_lock), .o_busy(o_busy), .o_sector_protected(o_sector_protected),
  .o_chunk_ecc_off(o_chunk_ecc_off));

// >>> test/sgt_host.sv
// Purpose: Host model framing SPI commands, mode 0, MSB first.
// Assumes: Called at a falling clock edge; sck period is 8 clocks.
// Notes:   Released mosi is inverted so no stale bit reads as valid.
`timescale 1ns/1ps
module sgt_host (
  // Clock
  input wire logic i_clock,
  // SPI pins
  output sgt_pkg::sgt_spi_in_s o_spi,
  input wire sgt_pkg::sgt_io_out_s i_io
);
  import sgt_pkg::*;
  logic [7:0] rx;
  logic [7:0] tr;
  logic oe_seen;
  initial o_spi = 3'b010;
  // Sample mid half period: old bit still held, next not yet out
  task automatic half(input bit smp, input bit trn);
    repeat (2) @(negedge i_clock);
    if (smp) rx = {rx[6:0], i_io.io[1]};
    if (trn) tr = {tr[6:0], i_io.io[0]};
    if (trn) oe_seen = oe_seen | (|i_io.oe);
    repeat (2) @(negedge i_clock);
  endtask
  task automatic frame(input logic [47:0] tx, input int n, input bit ddr);
    oe_seen = 1'b0;
    o_spi.cs_n = 1'b0;
    for (int j = 0; j <= n; j++) begin
      o_spi.sck = 1'b0;
      if (j < n) o_spi.mosi = tx[n-1-j];
      half(j > 0 && j < n, ddr && j >= 32 && j < n);
      if (j < n) o_spi.sck = 1'b1;
      if (j < n) half(1'b0, ddr && j >= 32);
    end
    o_spi.cs_n = 1'b1;
    o_spi.mosi = ~o_spi.mosi;
  endtask
endmodule

// >>> test/sgt_guard_tb.sv
// Purpose: Self-checking bench for sgt_guard.
// Assumes: Rows run in order, each on the state the last one left.
// Notes:   Row flags: read checked, error, sector 1 guarded, chunk 2 ECC off.
`timescale 1ns/1ps
module sgt_guard_tb;
  import sgt_pkg::*;
  typedef struct packed {logic [47:0] tx; int n; bit frz; logic [7:0] e; logic [3:0] f;} sgt_row_s;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic ship = 1'b1;
  logic frz = 1'b0;
  logic clr = 1'b0;
  logic [1:0] mode = 2'b10;
  logic [7:0] pat;
  int error_cnt = 0;
  int cmp_count = 0;
  sgt_spi_in_s spi;
  sgt_io_out_s io;
  logic err, lock, busy, prot, ecc;
  sgt_row_s rows [14] = '{
    '{48'hA700, 16, 0, 8'h01, 4'hA},
    '{48'hFC04000000, 40, 0, 8'hFF, 4'hA},
    '{48'hFB040000FF, 40, 0, 8'h00, 4'h0},
    '{48'hFD040000, 32, 0, 8'h00, 4'h2},
    '{48'hE20004000000, 48, 0, 8'h00, 4'hA},
    '{48'hE4, 8, 0, 8'h00, 4'h0},
    '{48'h435A, 16, 0, 8'h00, 4'h0},
    '{48'h4311, 16, 0, 8'h00, 4'h0},
    '{48'h4100, 16, 0, 8'h5A, 4'h8},
    '{48'h42000020F0, 40, 0, 8'h00, 4'h0},
    '{48'h420000203C, 40, 0, 8'h00, 4'h1},
    '{48'h4B0000200000, 48, 0, 8'h30, 4'h9},
    '{48'h4200040000, 40, 0, 8'h00, 4'h1},
    '{48'h4200004000, 40, 1, 8'h00, 4'h5}
  };
  always #50 clock = ~clock;
  sgt_host host (.i_clock(clock), .o_spi(spi), .i_io(io));
  sgt_guard dut (.i_clock(clock), .i_reset(reset), .i_ship_init(ship), .i_spi(spi),
    .o_io(io), .i_protection_mode(mode), .i_freeze(frz), .i_clear_program_error(clr),
    .o_program_error(err), .o_guard_lock(lock), .o_busy(busy), .i_query_sector(8'h01),
    .o_sector_protected(prot), .i_query_chunk(6'h02), .o_chunk_ecc_off(ecc));
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Error flag cleared first, so each command shows only its own effect
  task automatic run(input logic [47:0] tx, input int n, input bit ddr);
    @(negedge clock) clr = 1'b1;
    @(negedge clock) clr = 1'b0;
    host.frame(tx, n, ddr);
    repeat (16) @(negedge clock);
    for (int k = 0; busy !== 1'b0; k++) begin
      if (k == 100) error_cnt++;
      if (k == 100) summarize();
      @(negedge clock);
    end
  endtask
  initial begin
    repeat (16) @(negedge clock);
    reset = 1'b0;
    ship = 1'b0;
    repeat (4) @(negedge clock);
    foreach (rows[i]) begin
      frz = rows[i].frz;
      run(rows[i].tx, rows[i].n, 1'b0);
      check({1'b0, rows[i].f[3] ? host.rx : rows[i].e, err, prot, ecc},
        {1'b0, rows[i].e, rows[i].f[2:0]});
    end
    for (int i = 0; i < 2; i++) begin
      pat = i ? 8'h00 : 8'h34;
      run({32'h0, 8'h4A, pat}, 16, 1'b0);
      run(48'hEE0000000, 36, 1'b1);
      check({3'h0, host.oe_seen, host.oe_seen ? host.tr : 8'h00},
        {3'h0, pat != 8'h00, pat});
    end
    mode = 2'b01;
    reset = 1'b1;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    run(48'hA700, 16, 1'b0);
    check({3'h0, lock, host.rx}, 12'h000);
    run(48'hFD040000, 32, 1'b0);
    check({11'h0, err}, 12'h001);
    run(48'h4100, 16, 1'b0);
    check({4'h0, host.rx}, 12'h05A);
    summarize();
  end
endmodule
